// ### design/ext_memory_strobe_timing.sv
// External memory interface strobe timing sequencer with timing register and request buffer.
module ext_memory_strobe_timing #(
	parameter int FIFO_DEPTH_P = 16
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// Special function register port
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	// Bus configuration from neighbouring registers
	input wire logic [2:0] bus_mux_select_in,
	input wire logic [7:0] bank_select_register_in,
	// External move access requests
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic req_write_in,
	input wire logic req_wide_in,
	input wire logic [15:0] req_addr_in,
	input wire logic [7:0] req_wdata_in,
	// Access completion
	output logic done_out,
	output logic [7:0] rdata_out,
	output logic busy_out,
	// External memory pins
	output logic [7:0] addr_hi_out,
	output logic addr_hi_oe_out,
	output logic [7:0] addr_lo_out,
	output logic addr_lo_oe_out,
	output logic [7:0] ad_out,
	output logic ad_oe_out,
	input wire logic [7:0] ad_in,
	output logic ale_out,
	output logic rd_b_out,
	output logic wr_b_out
);
	import emif_pkg::*;

	// ==========================================================================
	// Reset release and pin synchronisers
	logic rst_s1_r;
	logic rst_b_r;
	logic [7:0] ad_s1_r;
	logic [7:0] ad_s2_r;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_s1_r <= 1'b0;
			rst_b_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_b_r <= rst_s1_r;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_r) begin
		if (!rst_b_r) begin
			ad_s1_r <= 8'h00;
			ad_s2_r <= 8'h00;
		end else begin
			ad_s1_r <= ad_in;
			ad_s2_r <= ad_s1_r;
		end
	end

	// ==========================================================================
	// Timing control register
	logic [7:0] tim_r;
	logic [7:0] sfr_rdata_r;
	wire tim_hit = (sfr_addr_in == TIMING_CTRL_ADDR);

	always_ff @(posedge sys_clk_in or negedge rst_b_r) begin
		if (!rst_b_r) begin
			tim_r <= TIMING_CTRL_RESET;
			sfr_rdata_r <= 8'h00;
		end else begin
			if (sfr_wr_in && tim_hit) tim_r <= sfr_wdata_in;
			if (sfr_rd_in) sfr_rdata_r <= tim_hit ? tim_r : 8'h00;
		end
	end
	assign sfr_rdata_out = sfr_rdata_r;

	// ==========================================================================
	// Request buffer
	stream_if #(.W(REQ_W)) req_s ();
	stream_if #(.W(REQ_W)) acc_s ();

	assign req_s.valid = req_valid_in;
	assign req_s.data = {req_write_in, req_wide_in, req_addr_in, req_wdata_in};
	assign req_ready_out = req_s.ready;

	req_fifo #(
		.WIDTH(REQ_W),
		.DEPTH(FIFO_DEPTH_P)
	) u_req_fifo (
		.clk_in(sys_clk_in),
		.rst_b_in(rst_b_r),
		.wr_s(req_s),
		.rd_s(acc_s)
	);

	// ==========================================================================
	// Access snapshot: settings are frozen for the whole access so a register
	// write in mid-access cannot tear a strobe.
	state_t state_r;
	state_t state_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [7:0] snap_tim_r;
	logic wr_r;
	logic wide_r;
	logic mux_r;
	logic bank_r;
	logic [15:0] addr_r;
	logic [7:0] wdata_r;
	logic [7:0] bank_byte_r;
	logic [7:0] rdata_r;
	logic done_r;
	logic pop;

	wire mux_mode = !bus_mux_select_in[MODE_SEPARATE_BIT];
	wire bank_mode = (bus_mux_select_in[1:0] == MODE_BANK_CODE);
	wire [1:0] addr_setup_cycles = snap_tim_r[SETUP_MSB:SETUP_LSB];
	wire [4:0] strobe_len = {1'b0, snap_tim_r[WIDTH_MSB:WIDTH_LSB]} + 5'h01;
	wire [1:0] addr_hold_cycles = snap_tim_r[HOLD_MSB:HOLD_LSB];
	wire last = (cnt_r == 5'h01);
	wire [4:0] cnt_dec = cnt_r - 5'h01;

	assign acc_s.ready = pop;

	// ==========================================================================
	// Phase sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = (state_r == ST_IDLE) ? cnt_r : cnt_dec;
		pop = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (acc_s.valid) begin
					pop = 1'b1;
					if (mux_mode) begin
						state_nxt = ST_ALE_HI;
						cnt_nxt = ALE_HIGH_CYCLES;
					end else begin
						state_nxt = ST_ADDR;
						cnt_nxt = ADDR_CYCLES;
					end
				end
			end
			ST_ALE_HI: begin
				if (last) begin
					state_nxt = ST_ALE_LO;
					cnt_nxt = ALE_LOW_CYCLES;
				end
			end
			ST_ALE_LO: begin
				if (last) begin
					state_nxt = ST_ADDR;
					cnt_nxt = ADDR_CYCLES;
				end
			end
			ST_ADDR: begin
				if (last && addr_setup_cycles != 2'h0) begin
					state_nxt = ST_SETUP;
					cnt_nxt = {3'h0, addr_setup_cycles};
				end else if (last) begin
					state_nxt = ST_STROBE;
					cnt_nxt = strobe_len;
				end
			end
			ST_SETUP: begin
				if (last) begin
					state_nxt = ST_STROBE;
					cnt_nxt = strobe_len;
				end
			end
			ST_STROBE: begin
				if (last && addr_hold_cycles != 2'h0) begin
					state_nxt = ST_HOLD;
					cnt_nxt = {3'h0, addr_hold_cycles};
				end else if (last) begin
					state_nxt = ST_TAIL;
					cnt_nxt = TAIL_CYCLES;
				end
			end
			ST_HOLD: begin
				if (last) begin
					state_nxt = ST_TAIL;
					cnt_nxt = TAIL_CYCLES;
				end
			end
			ST_TAIL: begin
				if (last) state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt = 5'h00;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_r) begin
		if (!rst_b_r) begin
			state_r <= ST_IDLE;
			cnt_r <= 5'h00;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			done_r <= (state_r == ST_TAIL) && last;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_r) begin
		if (!rst_b_r) begin
			snap_tim_r <= TIMING_CTRL_RESET;
			wr_r <= 1'b0;
			wide_r <= 1'b0;
			mux_r <= 1'b0;
			bank_r <= 1'b0;
			addr_r <= 16'h0000;
			wdata_r <= 8'h00;
			bank_byte_r <= 8'h00;
		end else if (pop) begin
			snap_tim_r <= tim_r;
			wr_r <= acc_s.data[REQ_WR_BIT];
			wide_r <= acc_s.data[REQ_WIDE_BIT];
			mux_r <= mux_mode;
			bank_r <= bank_mode;
			addr_r <= acc_s.data[REQ_ADDR_MSB:REQ_ADDR_LSB];
			wdata_r <= acc_s.data[REQ_DATA_MSB:0];
			bank_byte_r <= bank_select_register_in;
		end
	end

	// The pin is seen through the synchroniser, so the sample is two cycles
	// older than the strobe's last edge; slow memories need a wider strobe.
	always_ff @(posedge sys_clk_in or negedge rst_b_r) begin
		if (!rst_b_r) begin
			rdata_r <= 8'h00;
		end else if (state_r == ST_STROBE && last && !wr_r) begin
			rdata_r <= ad_s2_r;
		end
	end

	assign done_out = done_r;
	assign rdata_out = rdata_r;
	assign busy_out = (state_r != ST_IDLE);

	// ==========================================================================
	// Pin decode
	wire ale_phase = (state_r == ST_ALE_HI) || (state_r == ST_ALE_LO);
	wire data_phase = (state_r == ST_SETUP) || (state_r == ST_STROBE) || (state_r == ST_HOLD);
	wire addr_phase = ale_phase || (state_r == ST_ADDR) || data_phase;
	wire strobe_on = (state_r == ST_STROBE);
	wire upper_driven = wide_r || bank_r;

	assign ale_out = (state_r == ST_ALE_HI);
	assign rd_b_out = !(strobe_on && !wr_r);
	assign wr_b_out = !(strobe_on && wr_r);
	assign addr_hi_oe_out = addr_phase && upper_driven;
	assign addr_hi_out = wide_r ? addr_r[15:8] : bank_byte_r;
	assign addr_lo_oe_out = addr_phase && !mux_r;
	assign addr_lo_out = addr_r[7:0];
	assign ad_oe_out = (mux_r && ale_phase) || (wr_r && data_phase);
	assign ad_out = ale_phase ? addr_r[7:0] : wdata_r;

	// ==========================================================================
	// Checks
	logic [5:0] acc_len_r;
	logic [5:0] ph_len_r;
	wire [5:0] acc_expect = {4'h0, addr_setup_cycles} + {1'b0, strobe_len} + {4'h0, addr_hold_cycles}
		+ ACCESS_OVERHEAD + (mux_r ? MUX_OVERHEAD : 6'h00);

	always_ff @(posedge sys_clk_in or negedge rst_b_r) begin
		if (!rst_b_r) begin
			acc_len_r <= 6'h00;
			ph_len_r <= 6'h00;
		end else begin
			acc_len_r <= pop ? 6'h01 : acc_len_r + 6'h01;
			ph_len_r <= (state_nxt != state_r) ? 6'h01 : ph_len_r + 6'h01;
		end
	end

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_b_r);

	sequence ale_high_s;
		ale_out ##[1:4] !ale_out;
	endsequence

	sequence latch_low_s;
		(!ale_out && ale_phase) ##[1:4] (state_r == ST_ADDR && !ale_out);
	endsequence

	timing_reset_a: assert property ($rose(rst_b_r) |-> tim_r == TIMING_CTRL_RESET)
		else $error("Timing register not at maximum after reset");
	setup_len_a: assert property ((state_r == ST_SETUP && state_nxt != ST_SETUP)
		|-> ph_len_r == {4'h0, addr_setup_cycles})
		else $error("Address setup length wrong");
	strobe_len_a: assert property ((strobe_on && state_nxt != ST_STROBE)
		|-> ph_len_r == {1'b0, strobe_len} && (rd_b_out != wr_b_out))
		else $error("Strobe width wrong");
	hold_len_a: assert property ((state_r == ST_HOLD && state_nxt != ST_HOLD)
		|-> ph_len_r == {4'h0, addr_hold_cycles})
		else $error("Address hold length wrong");
	ale_high_a: assert property ($rose(ale_out) |-> ale_high_s)
		else $error("Latch high time out of range");
	ale_low_a: assert property ($fell(ale_out) |-> latch_low_s)
		else $error("Latch low time out of range");
	wdata_setup_a: assert property ($rose(wr_b_out) |-> $past(ad_oe_out) && !$past(ale_out))
		else $error("Write data not driven before strobe end");
	wdata_hold_a: assert property ($rose(wr_b_out) |-> ##[0:3] !ad_oe_out)
		else $error("Write data held too long");
	access_len_a: assert property ((state_r == ST_TAIL && last)
		|-> acc_len_r + 6'h01 == acc_expect)
		else $error("Access length wrong");
	mux_share_a: assert property (ale_out |-> mux_r && ad_oe_out && ad_out == addr_r[7:0]
		&& !addr_lo_oe_out)
		else $error("Latch phase without address on shared pins");
	separate_pins_a: assert property ((busy_out && !mux_r) |-> !ale_out
		&& (addr_phase == addr_lo_oe_out))
		else $error("Separate-pin mode misbehaves");
	upper_float_a: assert property ((addr_phase && !wide_r && !bank_r) |-> !addr_hi_oe_out)
		else $error("Upper address driven without bank select");
	bank_byte_a: assert property ((addr_phase && !wide_r && bank_r)
		|-> addr_hi_oe_out && addr_hi_out == bank_byte_r)
		else $error("Bank byte not on upper address");
	phase_order_a: assert property ((state_r == ST_STROBE) ##1 (state_r != ST_STROBE)
		|-> state_r inside {ST_HOLD, ST_TAIL})
		else $error("Phase order broken after strobe");
endmodule

// ### design/emif_pkg.sv
// Constants, field layout and state encoding of the external memory strobe timing sequencer.
package emif_pkg;

	// ==========================================================================
	// Register map and fields
	localparam logic [7:0] TIMING_CTRL_ADDR = 8'hAA;
	localparam logic [7:0] TIMING_CTRL_RESET = 8'hFF;
	localparam int SETUP_MSB = 7;
	localparam int SETUP_LSB = 6;
	localparam int WIDTH_MSB = 5;
	localparam int WIDTH_LSB = 2;
	localparam int HOLD_MSB = 1;
	localparam int HOLD_LSB = 0;

	// ==========================================================================
	// Mode field (three bits of the bus configuration)
	localparam int MODE_SEPARATE_BIT = 2;
	localparam logic [1:0] MODE_BANK_CODE = 2'h2;

	// ==========================================================================
	// Fixed phase lengths in system clock cycles
	localparam logic [4:0] ALE_HIGH_CYCLES = 5'h01;
	localparam logic [4:0] ALE_LOW_CYCLES = 5'h01;
	localparam logic [4:0] ADDR_CYCLES = 5'h01;
	localparam logic [4:0] TAIL_CYCLES = 5'h02;
	localparam logic [5:0] ACCESS_OVERHEAD = 6'h04;
	localparam logic [5:0] MUX_OVERHEAD = 6'h02;

	// ==========================================================================
	// Request word layout
	localparam int REQ_W = 26;
	localparam int REQ_WR_BIT = 25;
	localparam int REQ_WIDE_BIT = 24;
	localparam int REQ_ADDR_MSB = 23;
	localparam int REQ_ADDR_LSB = 8;
	localparam int REQ_DATA_MSB = 7;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ALE_HI = 8'h02,
		ST_ALE_LO = 8'h04,
		ST_ADDR = 8'h08,
		ST_SETUP = 8'h10,
		ST_STROBE = 8'h20,
		ST_HOLD = 8'h40,
		ST_TAIL = 8'h80
	} state_t;

endpackage

// ### design/stream_if.sv
// Valid/ready stream carrier between the sequencer and its request buffer.
interface stream_if #(
	parameter int W = 8
);
	logic valid;
	logic ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### design/req_fifo.sv
// Request buffer: flip-flop FIFO with valid/ready on both sides.
module req_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Streams
	stream_if.snk wr_s,
	stream_if.src rd_s
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	wire empty = (wp_r == rp_r);
	wire push = wr_s.valid && !full;
	wire pop = rd_s.ready && !empty;

	assign wr_s.ready = !full;
	assign rd_s.valid = !empty;
	assign rd_s.data = mem_r[rp_r[AW-1:0]];

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push) wp_r <= wp_r + 1'b1;
			if (pop) rp_r <= rp_r + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) mem_r[wp_r[AW-1:0]] <= wr_s.data;
	end

	fifo_bound_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		full |=> !$changed(wp_r)) else $error("FIFO pointer moved while full");
endmodule

// ### tb/ext_mem_model.sv
// Byte memory with clocked writes, combinational reads and a transparent address latch on the shared pins.
module ext_mem_model #(
	parameter logic [7:0] PORT_HI = 8'h00
) (
	// Clock and strobes
	input wire logic clk_in,
	input wire logic ale_in,
	input wire logic rd_b_in,
	input wire logic wr_b_in,
	// Address and data pins
	input wire logic [7:0] addr_hi_in,
	input wire logic addr_hi_oe_in,
	input wire logic [7:0] addr_lo_in,
	input wire logic addr_lo_oe_in,
	input wire logic [7:0] ad_dev_in,
	input wire logic ad_oe_in,
	output logic [7:0] ad_mem_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	logic [7:0] lat_r;
	logic [7:0] drv_r = 8'h5A;
	logic [15:0] addr;
	// ==========================================================================
	// Latch, decode and array
	always_latch begin
		if (ale_in) begin
			lat_r = ad_dev_in;
		end
	end
	// Undriven upper pins keep the port latch level, as a real board would.
	assign addr = {addr_hi_oe_in ? addr_hi_in : PORT_HI, addr_lo_oe_in ? addr_lo_in : lat_r};
	always @(posedge clk_in) begin
		if (!wr_b_in && ad_oe_in) begin
			mem[addr] <= ad_dev_in;
		end
		if (!rd_b_in) begin
			drv_r <= mem[addr];
		end
	end
	// Outside a read the pins show the inverse of the last byte, never a stale copy.
	assign ad_mem_out = rd_b_in ? ~drv_r : mem[addr];
endmodule

// ### tb/ext_memory_strobe_timing_tb.sv
// Self-checking bench of the strobe timing sequencer against a memory model.
module ext_memory_strobe_timing_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import emif_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [2:0] mode = 3'b101;
	logic [7:0] bank = 8'h00;
	logic req_valid = 1'b0;
	logic req_ready;
	logic req_write = 1'b0;
	logic req_wide = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic [7:0] req_wdata = 8'h00;
	logic done, busy, addr_hi_oe, addr_lo_oe, ad_oe, ale, rd_b, wr_b;
	logic [7:0] rdata, addr_hi, addr_lo, ad_o, ad_i;
	logic seen = 1'b0;
	int error_cnt = 0, n_tests = 0, cyc = 0, n_done = 0;
	int n_busy, n_ale, n_pre, n_strb, n_post, n_wds, n_wdh, n_hi;
	always #50 sys_clk = ~sys_clk;
	ext_memory_strobe_timing ext_memory_strobe_timing_i (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
		.sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd),
		.sfr_wdata_in(sfr_wdata), .sfr_rdata_out(sfr_rdata), .bus_mux_select_in(mode),
		.bank_select_register_in(bank), .req_valid_in(req_valid), .req_ready_out(req_ready),
		.req_write_in(req_write), .req_wide_in(req_wide), .req_addr_in(req_addr),
		.req_wdata_in(req_wdata), .done_out(done), .rdata_out(rdata), .busy_out(busy),
		.addr_hi_out(addr_hi), .addr_hi_oe_out(addr_hi_oe), .addr_lo_out(addr_lo),
		.addr_lo_oe_out(addr_lo_oe), .ad_out(ad_o), .ad_oe_out(ad_oe), .ad_in(ad_i),
		.ale_out(ale), .rd_b_out(rd_b), .wr_b_out(wr_b));
	ext_mem_model ext_mem_model_i (.clk_in(sys_clk), .ale_in(ale), .rd_b_in(rd_b),
		.wr_b_in(wr_b), .addr_hi_in(addr_hi), .addr_hi_oe_in(addr_hi_oe),
		.addr_lo_in(addr_lo), .addr_lo_oe_in(addr_lo_oe), .ad_dev_in(ad_o),
		.ad_oe_in(ad_oe), .ad_mem_out(ad_i));
	// ==========================================================================
	// Phase monitor and hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (done === 1'b1) n_done <= n_done + 1;
		if (busy === 1'b1) begin
			n_busy <= n_busy + 1;
			if (addr_hi_oe === 1'b1) n_hi <= n_hi + 1;
			if (rd_b === 1'b0 || wr_b === 1'b0) begin
				n_strb <= n_strb + 1;
				seen <= 1'b1;
				if (ad_oe === 1'b1) n_wds <= n_wds + 1;
			end else if (!seen) begin
				if (ale === 1'b1) n_ale <= n_ale + 1;
				else n_pre <= n_pre + 1;
				if (ad_oe === 1'b1 && ale !== 1'b1) n_wds <= n_wds + 1;
			end else begin
				n_post <= n_post + 1;
				if (ad_oe === 1'b1) n_wdh <= n_wdh + 1;
			end
		end
		if (cyc == 6000) begin
			error_cnt++;
			give_verdict;
		end
	end
	// ==========================================================================
	// Shared tasks
	task automatic give_verdict;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic chkn(input int got, input int exp, input string msg);
		n_tests++;
		if (got != exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, msg, got, exp);
		end
	endtask
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge sys_clk);
		sfr_wr = 1'b0;
	endtask
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge sys_clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask
	task automatic access(input logic w, input logic wide, input logic [15:0] a,
		input logic [7:0] d);
		int i;
		@(negedge sys_clk);
		{n_busy, n_ale, n_pre, n_strb, n_post, n_wds, n_wdh, n_hi} = '0;
		seen = 1'b0;
		req_write = w;
		req_wide = wide;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge sys_clk);
		@(negedge sys_clk);
		req_valid = 1'b0;
		for (i = 0; i < 100 && done !== 1'b1; i++) @(negedge sys_clk);
		chkn(int'(done === 1'b1), 1, "access done");
	endtask
	task automatic chk_phases(input logic [7:0] tm, input bit mux, input bit w);
		int addr_setup_cycles, strobe_width_cycles, addr_hold_cycles, m;
		addr_setup_cycles = tm[7:6];
		strobe_width_cycles = tm[5:2];
		addr_hold_cycles = tm[1:0];
		m = mux ? 2 : 0;
		chkn(n_pre, addr_setup_cycles + 1 + m / 2, "setup phase");
		chkn(n_strb, strobe_width_cycles + 1, "strobe width");
		chkn(n_post, addr_hold_cycles + 2, "hold phase");
		chkn(n_ale, m / 2, "latch high");
		chkn(n_busy + 1, addr_setup_cycles + strobe_width_cycles + addr_hold_cycles + 5 + m, "access length");
		if (w && !mux) begin
			chkn(n_wds, addr_setup_cycles + strobe_width_cycles + 1, "data setup");
			chkn(n_wdh, addr_hold_cycles, "data hold");
		end
	endtask
	// ==========================================================================
	// Scenarios
	task automatic t_regs;
		logic [7:0] d;
		sfr_read(TIMING_CTRL_ADDR, d);
		chk8(d, 8'hFF, "timing reset");
		sfr_write(8'h55, 8'h00);
		sfr_read(8'h55, d);
		chk8(d, 8'h00, "unmapped read");
		sfr_read(TIMING_CTRL_ADDR, d);
		chk8(d, 8'hFF, "unmapped write leak");
		sfr_write(TIMING_CTRL_ADDR, 8'h5A);
		sfr_read(TIMING_CTRL_ADDR, d);
		chk8(d, 8'h5A, "timing write");
		sfr_write(TIMING_CTRL_ADDR, TIMING_CTRL_RESET);
	endtask
	// The first pair runs on the reset settings, so the defaults are timed too.
	task automatic t_sweep;
		logic [7:0] tm [4] = '{8'hFF, 8'h00, 8'h49, 8'hB6};
		logic [7:0] t;
		for (int k = 0; k < 8; k++) begin
			t = tm[k / 2];
			mode = k[0] ? 3'b001 : 3'b101;
			if (k > 1 && !k[0]) sfr_write(TIMING_CTRL_ADDR, t);
			access(1'b1, 1'b1, 16'h0100 + 16'(k), 8'hA0 + 8'(k));
			chk_phases(t, k[0], 1'b1);
			chk8(ext_mem_model_i.mem[16'h0100 + 16'(k)], 8'hA0 + 8'(k), "wide write");
			if (t[5:2] > 4'h1) begin
				access(1'b0, 1'b1, 16'h0100 + 16'(k), 8'h00);
				chk_phases(t, k[0], 1'b0);
				chk8(rdata, 8'hA0 + 8'(k), "wide read");
			end
		end
	endtask
	// Reads need a strobe of three cycles so the synchroniser sees settled data.
	task automatic t_modes;
		logic [2:0] md [6] = '{3'b101, 3'b110, 3'b111, 3'b001, 3'b010, 3'b011};
		logic [7:0] hi, lo;
		bank = 8'hC3;
		sfr_write(TIMING_CTRL_ADDR, 8'h49);
		for (int k = 0; k < 6; k++) begin
			mode = md[k];
			lo = 8'h20 + 8'(k);
			hi = (md[k][1:0] == 2'b10) ? 8'hC3 : 8'h00;
			access(1'b1, 1'b0, {8'h77, lo}, 8'h50 + 8'(k));
			chk8(ext_mem_model_i.mem[{hi, lo}], 8'h50 + 8'(k), "byte write");
			if (hi == 8'h00) chkn(n_hi, 0, "upper pins driven");
			access(1'b0, 1'b0, {8'h77, lo}, 8'h00);
			chk8(rdata, 8'h50 + 8'(k), "byte read");
			access(1'b1, 1'b1, {8'h44 + 8'(k), 8'h30}, 8'h60 + 8'(k));
			chkn(n_hi, n_busy - 2, "wide upper pins");
			access(1'b0, 1'b1, {8'h44 + 8'(k), 8'h30}, 8'h00);
			chk_phases(8'h49, !md[k][2], 1'b0);
			chk8(rdata, 8'h60 + 8'(k), "wide mode read");
		end
	endtask
	task automatic t_fifo;
		int acc, base, i;
		sfr_write(TIMING_CTRL_ADDR, TIMING_CTRL_RESET);
		mode = 3'b101;
		base = n_done;
		acc = 0;
		@(negedge sys_clk);
		req_write = 1'b1;
		req_wide = 1'b1;
		req_valid = 1'b1;
		while (req_ready === 1'b1 && acc < 20) begin
			req_addr = 16'h0200 + 16'(acc);
			req_wdata = 8'h10 + 8'(acc);
			@(negedge sys_clk);
			acc++;
		end
		req_valid = 1'b0;
		chkn(acc, FIFO_DEPTH + 1, "buffer depth");
		for (i = 0; i < 1000 && n_done - base < acc; i++) @(negedge sys_clk);
		chkn(n_done - base, acc, "drained");
		chk8(ext_mem_model_i.mem[16'h0200 + 16'(acc - 1)], 8'h10 + 8'(acc - 1), "last write");
		chk8(req_ready, 1'b1, "ready after drain");
	endtask
	initial begin
		repeat (10) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge sys_clk);
		t_regs;
		t_sweep;
		t_modes;
		t_fifo;
		give_verdict;
	end
endmodule
